// *** logic/sensor_port_pkg.sv ***
// =============================================================
// shared constants and types of the three-wire sensor port
package sensor_port_pkg;
	// command framing around the setup field
	localparam logic [2:0]  START_BITS    = 3'h7;
	localparam logic [2:0]  STOP_BITS     = 3'h0;
	// setup field codes
	localparam logic [3:0]  SETUP_PRESSURE    = 4'ha;
	localparam logic [3:0]  SETUP_TEMPERATURE = 4'h9;
	localparam logic [3:0]  SETUP_WORD_ONE    = 4'h5;
	localparam logic [3:0]  SETUP_WORD_TWO    = 4'h6;
	localparam logic [3:0]  SETUP_WORD_THREE  = 4'hc;
	localparam logic [3:0]  SETUP_WORD_FOUR   = 4'h3;
	// resynchronising pattern, oldest bit in bit 20
	localparam logic [20:0] RESET_PATTERN = 21'h155540;
	// serial clock counts
	localparam logic [4:0]  ACK_CLOCKS    = 5'h02;
	localparam logic [4:0]  SHIFT_CLOCKS  = 5'h11;
	// conversion length in master clock rising edges
	localparam logic [7:0]  CONV_MCLK_EDGES = 8'h20;
	// factory coefficient store content, value is arbitrary
	localparam logic [63:0] FACTORY_COEFFICIENT_STORE = 64'h1234_5678_9abc_def0;
	// which quantity a conversion measures
	typedef enum logic {KIND_PRESSURE, KIND_TEMPERATURE} conv_kind_type;
	// protocol phases
	typedef enum logic [1:0] {PHASE_IDLE, PHASE_ACK, PHASE_CONVERT, PHASE_SHIFT} phase_type;
endpackage : sensor_port_pkg

// *** logic/conv_if.sv ***
`timescale 1ns/1ps
// =============================================================
// link between protocol logic and the conversion engine
interface conv_if;
	logic                           start;
	logic                           abort;
	sensor_port_pkg::conv_kind_type kind;
	logic                           busy;
	logic                           done;
	logic [15:0]                    result;
	modport ctrl   (output start, output abort, output kind, input busy, input done, input result);
	modport engine (input start, input abort, input kind, output busy, output done, output result);
endinterface : conv_if

// *** logic/conversion_engine.sv ***
`timescale 1ns/1ps
// =============================================================
// conversion timer paced by the master clock
module conversion_engine (
	// clock and reset
	input  wire logic  clk,
	input  wire logic  sys_rst,
	// master clock rising-edge enable
	input  wire logic  mclkTick,
	// front-end samples, same clock domain
	input  wire logic [15:0] pressureSample,
	input  wire logic [15:0] temperatureSample,
	// control link
	conv_if.engine     conv
);
	logic                           busy,  next_busy;
	logic                           done,  next_done;
	logic [7:0]                     count, next_count;
	logic [15:0]                    result, next_result;
	sensor_port_pkg::conv_kind_type kind,  next_kind;

	// abort beats start so a resync never leaves a conversion running
	always_comb begin
		next_busy   = busy;
		next_done   = 1'b0;
		next_count  = count;
		next_result = result;
		next_kind   = kind;
		if (conv.abort) begin
			next_busy  = 1'b0;
			next_count = 8'h00;
		end else if (conv.start) begin
			next_busy  = 1'b1;
			next_count = 8'h00;
			next_kind  = conv.kind;
		end else if (busy && mclkTick) begin
			if (count == sensor_port_pkg::CONV_MCLK_EDGES - 8'h01) begin
				next_busy   = 1'b0;
				next_done   = 1'b1;
				next_result = (kind == sensor_port_pkg::KIND_TEMPERATURE) ?
					temperatureSample : pressureSample;
			end else begin
				next_count = count + 8'h01;
			end
		end
	end

	// engine state
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy   <= 1'b0;
			done   <= 1'b0;
			count  <= 8'h00;
			result <= 16'h0000;
			kind   <= sensor_port_pkg::KIND_PRESSURE;
		end else begin
			busy   <= next_busy;
			done   <= next_done;
			count  <= next_count;
			result <= next_result;
			kind   <= next_kind;
		end
	end

	assign conv.busy   = busy;
	assign conv.done   = done;
	assign conv.result = result;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	done_after_busy_a: assert property (done |-> $past(busy) && !busy)
		else $error("conversion done without a running conversion");
endmodule : conversion_engine

// *** logic/pressure_sensor_three_wire_port.sv ***
`timescale 1ns/1ps
// How it works
// - instruction bits sampled and output bits launched on serial clock rising edges
// - output carries result or calibration data chosen by last instruction, plus status
// - seven commands: pressure, temperature, four calibration words, reset
// - command framed by three high bits, setup field, three low bits
// - four-bit setup field selects pressure, temperature or calibration word
// - accepted conversion command acknowledged by output rising low to high
// - conversion end shown by output falling high to low
// - seventeen further clocks shift out the sixteen-bit result
// - readout pauses while clock stands still and resumes where it stopped
// - twenty-one bit pattern returns port to idle from any state
// - sixty-four bit factory store returned by calibration read commands
// - store organised as four sixteen-bit words, one read command each
// - pressure and temperature are unsigned sixteen-bit results of one converter
module pressure_sensor_three_wire_port (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// serial pins
	input  wire logic        serialClock,
	input  wire logic        instructionIn,
	output logic             dataOut,
	// converter master clock pin
	input  wire logic        masterClock,
	// analog front-end samples
	input  wire logic [15:0] pressureSample,
	input  wire logic [15:0] temperatureSample
);
	// =============================================================
	// pin synchronisers and edge finders
	logic [2:0] pinRaw;
	logic [2:0] pinMeta;
	logic [2:0] pinSync;
	logic [2:0] pinLast;
	logic       sclkRise;
	logic       dinBit;
	logic       mclkTick;

	assign pinRaw = {masterClock, instructionIn, serialClock};

	// edge finders read the second and third stages, never the first
	generate
		for (genvar i = 0; i < 3; i++) begin : g_sync
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					pinMeta[i] <= 1'b0;
					pinSync[i] <= 1'b0;
					pinLast[i] <= 1'b0;
				end else begin
					pinMeta[i] <= pinRaw[i];
					pinSync[i] <= pinMeta[i];
					pinLast[i] <= pinSync[i];
				end
			end
		end
	endgenerate

	assign sclkRise = pinSync[0] & ~pinLast[0];
	assign dinBit   = pinSync[1];
	assign mclkTick = pinSync[2] & ~pinLast[2];

	// =============================================================
	// conversion engine
	conv_if conv ();

	conversion_engine u_engine (
		.clk               (clk),
		.sys_rst           (sys_rst),
		.mclkTick          (mclkTick),
		.pressureSample    (pressureSample),
		.temperatureSample (temperatureSample),
		.conv              (conv.engine)
	);

	// =============================================================
	// protocol state
	sensor_port_pkg::phase_type     phase,     next_phase;
	logic [20:0]                    history,   next_history;
	logic [4:0]                     bitCount,  next_bitCount;
	logic [15:0]                    shiftData, next_shiftData;
	logic                           next_dataOut;
	logic                           convStart, next_convStart;
	logic                           convAbort, next_convAbort;
	sensor_port_pkg::conv_kind_type convKind,  next_convKind;
	logic [20:0]                    shifted;
	logic                           cmdSeen;
	logic [3:0]                     setupCode;

	// newest bit enters at bit 0
	assign shifted   = {history[19:0], dinBit};
	assign setupCode = shifted[6:3];
	assign cmdSeen   = (shifted[9:7] == sensor_port_pkg::START_BITS) &&
		(shifted[2:0] == sensor_port_pkg::STOP_BITS);

	// history is cleared on each accepted command so stale bits cannot retrigger
	always_comb begin
		next_phase     = phase;
		next_history   = history;
		next_bitCount  = bitCount;
		next_shiftData = shiftData;
		next_dataOut   = dataOut;
		next_convStart = 1'b0;
		next_convAbort = 1'b0;
		next_convKind  = convKind;
		if (sclkRise) begin
			next_history = shifted;
			if (shifted == sensor_port_pkg::RESET_PATTERN) begin
				next_phase     = sensor_port_pkg::PHASE_IDLE;
				next_history   = 21'h000000;
				next_bitCount  = 5'h00;
				next_dataOut   = 1'b0;
				next_convAbort = 1'b1;
			end else begin
				case (phase)
					sensor_port_pkg::PHASE_IDLE: begin
						next_dataOut = 1'b0;
						if (cmdSeen) begin
							next_bitCount = 5'h00;
							case (setupCode)
								sensor_port_pkg::SETUP_PRESSURE,
								sensor_port_pkg::SETUP_TEMPERATURE: begin
									next_phase    = sensor_port_pkg::PHASE_ACK;
									next_dataOut  = 1'b1;
									next_history  = 21'h000000;
									next_convKind = (setupCode == sensor_port_pkg::SETUP_TEMPERATURE) ?
										sensor_port_pkg::KIND_TEMPERATURE :
										sensor_port_pkg::KIND_PRESSURE;
								end
								sensor_port_pkg::SETUP_WORD_ONE: begin
									next_phase     = sensor_port_pkg::PHASE_SHIFT;
									next_history   = 21'h000000;
									next_shiftData = sensor_port_pkg::FACTORY_COEFFICIENT_STORE[63:48];
								end
								sensor_port_pkg::SETUP_WORD_TWO: begin
									next_phase     = sensor_port_pkg::PHASE_SHIFT;
									next_history   = 21'h000000;
									next_shiftData = sensor_port_pkg::FACTORY_COEFFICIENT_STORE[47:32];
								end
								sensor_port_pkg::SETUP_WORD_THREE: begin
									next_phase     = sensor_port_pkg::PHASE_SHIFT;
									next_history   = 21'h000000;
									next_shiftData = sensor_port_pkg::FACTORY_COEFFICIENT_STORE[31:16];
								end
								sensor_port_pkg::SETUP_WORD_FOUR: begin
									next_phase     = sensor_port_pkg::PHASE_SHIFT;
									next_history   = 21'h000000;
									next_shiftData = sensor_port_pkg::FACTORY_COEFFICIENT_STORE[15:0];
								end
								default: begin
									next_phase = sensor_port_pkg::PHASE_IDLE;
								end
							endcase
						end
					end
					sensor_port_pkg::PHASE_ACK: begin
						// the controller's two extra clocks, then conversion runs
						if (bitCount == sensor_port_pkg::ACK_CLOCKS - 5'h01) begin
							next_phase     = sensor_port_pkg::PHASE_CONVERT;
							next_bitCount  = 5'h00;
							next_convStart = 1'b1;
						end else begin
							next_bitCount = bitCount + 5'h01;
						end
					end
					sensor_port_pkg::PHASE_CONVERT: begin
						// clock should stand low here; stray edges are ignored
						next_phase = sensor_port_pkg::PHASE_CONVERT;
					end
					sensor_port_pkg::PHASE_SHIFT: begin
						if (bitCount == sensor_port_pkg::SHIFT_CLOCKS - 5'h01) begin
							next_phase    = sensor_port_pkg::PHASE_IDLE;
							next_bitCount = 5'h00;
							next_dataOut  = 1'b0;
						end else begin
							next_dataOut   = shiftData[15];
							next_shiftData = {shiftData[14:0], 1'b0};
							next_bitCount  = bitCount + 5'h01;
						end
					end
					default: begin
						next_phase = sensor_port_pkg::PHASE_IDLE;
					end
				endcase
			end
		end else if (phase == sensor_port_pkg::PHASE_CONVERT && conv.done) begin
			next_phase     = sensor_port_pkg::PHASE_SHIFT;
			next_dataOut   = 1'b0;
			next_shiftData = conv.result;
			next_bitCount  = 5'h00;
		end
	end

	// register stage; without an edge only conversion end and the start/abort strobes change anything, which pauses readout
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			phase     <= sensor_port_pkg::PHASE_IDLE;
			history   <= 21'h000000;
			bitCount  <= 5'h00;
			shiftData <= 16'h0000;
			dataOut   <= 1'b0;
			convStart <= 1'b0;
			convAbort <= 1'b0;
			convKind  <= sensor_port_pkg::KIND_PRESSURE;
		end else begin
			phase     <= next_phase;
			history   <= next_history;
			bitCount  <= next_bitCount;
			shiftData <= next_shiftData;
			dataOut   <= next_dataOut;
			convStart <= next_convStart;
			convAbort <= next_convAbort;
			convKind  <= next_convKind;
		end
	end

	assign conv.start = convStart;
	assign conv.abort = convAbort;
	assign conv.kind  = convKind;

	// =============================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence convAccepted;
		sclkRise && phase == sensor_port_pkg::PHASE_IDLE && cmdSeen &&
		shifted != sensor_port_pkg::RESET_PATTERN &&
		(setupCode == sensor_port_pkg::SETUP_PRESSURE ||
		setupCode == sensor_port_pkg::SETUP_TEMPERATURE);
	endsequence

	sequence convFinished;
		!sclkRise && phase == sensor_port_pkg::PHASE_CONVERT && conv.done;
	endsequence

	// last of the controller's post-acknowledge clocks, not part of a resync
	sequence lastAckClock;
		sclkRise && phase == sensor_port_pkg::PHASE_ACK &&
		bitCount == sensor_port_pkg::ACK_CLOCKS - 5'h01 &&
		shifted != sensor_port_pkg::RESET_PATTERN;
	endsequence

	conv_ack_rise_a: assert property (convAccepted |=> dataOut && $rose(dataOut))
		else $error("conversion accepted without acknowledge");
	conv_end_fall_a: assert property (convFinished |=> $fell(dataOut) &&
		phase == sensor_port_pkg::PHASE_SHIFT && bitCount == 5'h00)
		else $error("conversion end not shown on output");
	history_on_edge_a: assert property ($changed(history) |-> $past(sclkRise))
		else $error("input sampled without serial clock edge");
	launch_on_edge_a: assert property (phase == sensor_port_pkg::PHASE_SHIFT &&
		$changed(dataOut) |-> $past(sclkRise) || $past(conv.done))
		else $error("output bit launched without serial clock edge");
	reset_to_idle_a: assert property (sclkRise &&
		shifted == sensor_port_pkg::RESET_PATTERN |=> phase == sensor_port_pkg::PHASE_IDLE &&
		!dataOut ##1 !conv.busy)
		else $error("reset pattern did not return port to idle");
	readout_pause_a: assert property (phase == sensor_port_pkg::PHASE_SHIFT &&
		!sclkRise |=> $stable(bitCount) && $stable(shiftData))
		else $error("readout position moved without clock");
	shift_length_a: assert property (bitCount <= sensor_port_pkg::SHIFT_CLOCKS - 5'h01)
		else $error("readout ran past seventeen clocks");
	cal_msb_first_a: assert property (sclkRise && phase == sensor_port_pkg::PHASE_SHIFT &&
		bitCount == 5'h00 && shifted != sensor_port_pkg::RESET_PATTERN
		|=> dataOut == $past(shiftData[15]))
		else $error("first shifted bit is not the msb");
	ack_then_start_a: assert property (lastAckClock |=> convStart &&
		phase == sensor_port_pkg::PHASE_CONVERT && dataOut)
		else $error("conversion not started after two clocks");
endmodule : pressure_sensor_three_wire_port

// *** test/sensor_controller_model.sv ***
`timescale 1ns/1ps
// =============================================================
// behavioural controller on the far side of the three-wire port
module sensor_controller_model (
	// serial pins
	output logic      serialClock,
	output logic      instructionIn,
	input  wire logic dataOut
);
	// the clock rests low between frames and is driven only from here
	initial begin
		serialClock   = 1'b0;
		instructionIn = 1'b0;
	end

	// one serial clock: input changed in the low phase, output taken at the fall
	// 3:1 duty keeps the input steady across the rise and lets the output settle first
	task automatic clockBit(input logic b, output logic sample);
		instructionIn = b;
		#100;
		serialClock = 1'b1;
		#300;
		serialClock = 1'b0;
		sample = dataOut;
	endtask : clockBit

	// start bits, setup field msb first, stop bits; returns output after the last stop bit
	task automatic sendCommand(input logic [3:0] setup, output logic last);
		logic [9:0] frame;
		frame = {3'h7, setup, 3'h0};
		for (int i = 9; i >= 0; i--) begin
			clockBit(frame[i], last);
		end
	endtask : sendCommand

	// resync pattern; the output is disregarded all through it
	task automatic sendReset();
		logic s;
		for (int i = 20; i >= 0; i--) begin
			clockBit(sensor_port_pkg::RESET_PATTERN[i], s);
		end
	endtask : sendReset
endmodule : sensor_controller_model

// *** test/tb.sv ***
`timescale 1ns/1ps
// =============================================================
// self-checking bench of the three-wire sensor port
module tb;
	logic        clk;
	logic        sys_rst;
	logic        masterClock;
	logic [15:0] pressureSample;
	logic [15:0] temperatureSample;
	wire         serialClock;
	wire         instructionIn;
	wire         dataOut;
	int          fails;
	int          tests_run;
	logic [31:0] seed;
	logic        s;
	logic        expBits[$];

	pressure_sensor_three_wire_port u_dut (
		.clk              (clk),
		.sys_rst          (sys_rst),
		.serialClock      (serialClock),
		.instructionIn    (instructionIn),
		.dataOut          (dataOut),
		.masterClock      (masterClock),
		.pressureSample   (pressureSample),
		.temperatureSample(temperatureSample)
	);
	sensor_controller_model u_ctrl (
		.serialClock  (serialClock),
		.instructionIn(instructionIn),
		.dataOut      (dataOut)
	);

	// =============================================================
	// clocks; master clock far faster than a watch crystal to keep the run short
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		masterClock = 1'b0;
		forever #210 masterClock = ~masterClock;
	end
	// hang guard, counts as a mismatch
	initial begin
		#3000000;
		fails++;
		finish_test();
	end

	// =============================================================
	// helpers
	function automatic logic [31:0] xorshift(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction : xorshift

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic finish_test();
		if (fails == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test

	// model side: queue the sixteen bits msb first
	task automatic expectWord(input logic [15:0] w);
		for (int i = 15; i >= 0; i--) begin
			expBits.push_back(w[i]);
		end
	endtask : expectWord

	// sixteen data clocks with a hold of the clock, then the closing clock
	task automatic readOut(input int pauseAt);
		for (int i = 0; i < 16; i++) begin
			if (i == pauseAt)
				#2000;
			u_ctrl.clockBit(1'b0, s);
			check({15'h0, s}, {15'h0, expBits.pop_front()});
		end
		u_ctrl.clockBit(1'b0, s);
		check({15'h0, s}, 16'h0);
	endtask : readOut

	// conversion with acknowledge, two extra clocks, bounded wait for its end
	task automatic convert(input logic [3:0] code, input logic isTemp, input int pauseAt);
		int n;
		int lo;
		lo = (int'(sensor_port_pkg::CONV_MCLK_EDGES) - 1) * 420 / 50 - 4;
		seed = xorshift(seed);
		@(negedge clk);
		pressureSample    = seed[15:0];
		temperatureSample = seed[31:16];
		u_ctrl.sendReset();
		u_ctrl.sendCommand(code, s);
		check({15'h0, s}, 16'h1);
		for (int i = 0; i < 2; i++) begin
			u_ctrl.clockBit(1'b0, s);
			check({15'h0, s}, 16'h1);
		end
		n = 0;
		while (dataOut !== 1'b0 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		if (n == 2000) begin
			fails++;
			finish_test();
		end
		check({15'h0, n >= lo && n <= lo + 20}, 16'h1);
		expectWord(isTemp ? temperatureSample : pressureSample);
		readOut(pauseAt);
	endtask : convert

	// calibration word: no acknowledge, bits follow the stop bits
	task automatic readWord(input int idx, input int pauseAt);
		logic [3:0] codes [4];
		codes = '{sensor_port_pkg::SETUP_WORD_ONE, sensor_port_pkg::SETUP_WORD_TWO,
			sensor_port_pkg::SETUP_WORD_THREE, sensor_port_pkg::SETUP_WORD_FOUR};
		u_ctrl.sendCommand(codes[idx], s);
		check({15'h0, s}, 16'h0);
		expectWord(sensor_port_pkg::FACTORY_COEFFICIENT_STORE[63 - 16 * idx -: 16]);
		readOut(pauseAt);
	endtask : readWord

	// =============================================================
	// main sequence
	initial begin
		fails             = 0;
		tests_run         = 0;
		seed              = 32'hf8049462;
		sys_rst           = 1'b1;
		pressureSample    = 16'h0000;
		temperatureSample = 16'h0000;
		repeat (4) @(posedge clk);
		@(negedge clk);
		sys_rst = 1'b0;
		check({15'h0, dataOut}, 16'h0);
		repeat (3) @(negedge clk);
		// unknown setup code leaves the port idle
		u_ctrl.sendCommand(4'h0, s);
		check({15'h0, s}, 16'h0);
		for (int i = 0; i < 4; i++) begin
			u_ctrl.clockBit(1'b0, s);
			check({15'h0, s}, 16'h0);
		end
		// all four words back to back, each paused at a different bit
		u_ctrl.sendReset();
		for (int i = 0; i < 4; i++) begin
			readWord(i, i * 5);
		end
		// both conversion kinds, with pauses at the first, last and a middle bit of the readout
		convert(sensor_port_pkg::SETUP_PRESSURE, 1'b0, 0);
		convert(sensor_port_pkg::SETUP_TEMPERATURE, 1'b1, 15);
		convert(sensor_port_pkg::SETUP_PRESSURE, 1'b0, 8);
		// resync pattern aborts a running conversion
		u_ctrl.sendReset();
		u_ctrl.sendCommand(sensor_port_pkg::SETUP_TEMPERATURE, s);
		check({15'h0, s}, 16'h1);
		u_ctrl.sendReset();
		repeat (10) @(negedge clk);
		check({15'h0, dataOut}, 16'h0);
		readWord(2, 3);
		convert(sensor_port_pkg::SETUP_TEMPERATURE, 1'b1, 4);
		finish_test();
	end
endmodule : tb
